//--- src/spi_flash_map.svh
`ifndef SPI_FLASH_MAP_SVH
`define SPI_FLASH_MAP_SVH
// phase sizes in bits, dummy lengths in serial clocks
`define OPC_BITS 6'h08
`define ADR_BITS 6'h18
`define MODE_BITS 6'h08
`define BYTE_BITS 6'h08
`define NO_DUMMY 6'h00
`define DUMMY_2 6'h02
`define DUMMY_4 6'h04
`define DUMMY_6 6'h06
`define DUMMY_8 6'h08
`define DUMMY_32 6'h20
// lane widths of the phase_width_code digits
`define W0 3'h0
`define W1 3'h1
`define W2 3'h2
`define W4 3'h4
// fixed data byte counts; open means until chip select rises
`define NB_OPEN 2'h0
`define NB_ONE 2'h1
`define NB_TWO 2'h2
`define NB_THREE 2'h3
// continuous_read_mode_bits[5:4] value that keeps the opcode skipped
`define CONT_KEEP 2'h2
// output enables, active low, lane 0 is the host data-out line
`define OE_N_IDLE 4'hf
`define OE_N_LANE0 4'he
`define OE_N_LANE1 4'hd
`define OE_N_DUAL 4'hc
`define OE_N_QUAD 4'h0
`define OP_RESET_EN 8'h66
`define OP_RESET 8'h99
`define OP_PWR_DOWN 8'hb9
`define OP_PWR_UP 8'hab
`define OP_WR_EN 8'h06
`define OP_VSR_WR_EN 8'h50
`define OP_WR_DIS 8'h04
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_READ_DO 8'h3b
`define OP_READ_DIO 8'hbb
`define OP_READ_QO 8'h6b
`define OP_READ_QIO 8'heb
`define OP_WORD_QIO 8'he7
`define OP_BURST_WRAP 8'h77
`define OP_PROG 8'h02
`define OP_QPROG 8'h32
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_RD_SR1 8'h05
`define OP_RD_SR2 8'h35
`define OP_RD_SR3 8'h15
`define OP_WR_SR1 8'h01
`define OP_WR_SR2 8'h31
`define OP_WR_SR3 8'h11
`define OP_ID 8'h90
`define OP_ID_DUAL 8'h92
`define OP_ID_QUAD 8'h94
`define OP_JEDEC_ID 8'h9f
`define OP_PARAM_TBL 8'h5a
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define OP_SEC_READ 8'h48
`define OP_UID 8'h4b
`endif

//--- src/spi_flash_pkg.sv
`include "spi_flash_map.svh"
package spi_flash_pkg;
  typedef logic [7:0] opcode_t;
  typedef logic [23:0] addr_t;
  typedef logic [2:0] width_t;
  typedef enum logic [6:0] {
    PH_IDLE = 7'h01,
    PH_OPC = 7'h02,
    PH_ADDR = 7'h04,
    PH_MODE = 7'h08,
    PH_DUMMY = 7'h10,
    PH_DATA = 7'h20,
    PH_DONE = 7'h40
  } phase_e;
  typedef struct packed {
    logic known;
    width_t ad_w;
    logic has_mode;
    logic [5:0] dummy;
    width_t da_w;
    logic da_out;
    logic [1:0] nb;
  } phase_width_code_s;

  function automatic phase_width_code_s mk(width_t ad, logic md, logic [5:0] dm, width_t da,
                                           logic dout, logic [1:0] nb);
    return '{1'h1, ad, md, dm, da, dout, nb};
  endfunction

  function automatic phase_width_code_s decode(opcode_t op);
    phase_width_code_s c;
    c = '0;
    case (op)
      `OP_RESET_EN, `OP_RESET, `OP_PWR_DOWN, `OP_PWR_UP, `OP_WR_EN, `OP_VSR_WR_EN,
      `OP_WR_DIS, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_SUSPEND, `OP_RESUME:
        c = mk(`W0, 1'h0, `NO_DUMMY, `W0, 1'h0, `NB_OPEN);
      `OP_READ: c = mk(`W1, 1'h0, `NO_DUMMY, `W1, 1'h1, `NB_OPEN);
      `OP_FAST_READ, `OP_SEC_READ, `OP_PARAM_TBL:
        c = mk(`W1, 1'h0, `DUMMY_8, `W1, 1'h1, `NB_OPEN);
      `OP_READ_DO: c = mk(`W1, 1'h0, `DUMMY_8, `W2, 1'h1, `NB_OPEN);
      `OP_READ_QO: c = mk(`W1, 1'h0, `DUMMY_8, `W4, 1'h1, `NB_OPEN);
      `OP_READ_DIO: c = mk(`W2, 1'h1, `NO_DUMMY, `W2, 1'h1, `NB_OPEN);
      `OP_READ_QIO: c = mk(`W4, 1'h1, `DUMMY_4, `W4, 1'h1, `NB_OPEN);
      `OP_WORD_QIO: c = mk(`W4, 1'h1, `DUMMY_2, `W4, 1'h1, `NB_OPEN);
      `OP_BURST_WRAP: c = mk(`W0, 1'h0, `DUMMY_6, `W4, 1'h0, `NB_ONE);
      `OP_PROG, `OP_SEC_PROG: c = mk(`W1, 1'h0, `NO_DUMMY, `W1, 1'h0, `NB_OPEN);
      `OP_QPROG: c = mk(`W1, 1'h0, `NO_DUMMY, `W4, 1'h0, `NB_OPEN);
      `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K, `OP_SEC_ERASE:
        c = mk(`W1, 1'h0, `NO_DUMMY, `W0, 1'h0, `NB_OPEN);
      `OP_RD_SR1, `OP_RD_SR2, `OP_RD_SR3: c = mk(`W0, 1'h0, `NO_DUMMY, `W1, 1'h1, `NB_ONE);
      `OP_WR_SR1, `OP_WR_SR2, `OP_WR_SR3: c = mk(`W0, 1'h0, `NO_DUMMY, `W1, 1'h0, `NB_ONE);
      `OP_ID: c = mk(`W1, 1'h0, `NO_DUMMY, `W1, 1'h1, `NB_TWO);
      `OP_ID_DUAL: c = mk(`W2, 1'h0, `DUMMY_4, `W2, 1'h1, `NB_TWO);
      `OP_ID_QUAD: c = mk(`W4, 1'h0, `DUMMY_4, `W4, 1'h1, `NB_TWO);
      `OP_JEDEC_ID: c = mk(`W0, 1'h0, `NO_DUMMY, `W1, 1'h1, `NB_THREE);
      `OP_UID: c = mk(`W0, 1'h0, `DUMMY_32, `W1, 1'h1, `NB_OPEN);
      default: c = '0;
    endcase
    return c;
  endfunction

  function automatic logic [5:0] clks(logic [5:0] bits, width_t w);
    case (w)
      `W1: return bits;
      `W2: return bits >> 1;
      `W4: return bits >> 2;
      default: return '0;
    endcase
  endfunction

  function automatic width_t phase_width(phase_e ph, phase_width_code_s c);
    case (ph)
      PH_OPC, PH_DUMMY: return `W1;
      PH_ADDR, PH_MODE: return c.ad_w;
      PH_DATA: return c.da_w;
      default: return `W0;
    endcase
  endfunction

  // serial clocks of one phase, minus one, as loaded into the clock counters
  function automatic logic [5:0] len_m1(phase_e ph, phase_width_code_s c);
    logic [5:0] n;
    case (ph)
      PH_OPC: n = clks(`OPC_BITS, `W1);
      PH_ADDR: n = clks(`ADR_BITS, c.ad_w);
      PH_MODE: n = clks(`MODE_BITS, c.ad_w);
      PH_DUMMY: n = c.dummy;
      PH_DATA: n = clks(`BYTE_BITS, c.da_w);
      default: n = 6'h01;
    endcase
    return 6'(n - 6'h01);
  endfunction

  function automatic phase_e next_phase(phase_e ph, phase_width_code_s c);
    phase_e n;
    n = PH_DONE;
    if (c.da_w != `W0 && ph != PH_DATA)
      n = PH_DATA;
    if (c.dummy != `NO_DUMMY && (ph == PH_OPC || ph == PH_ADDR || ph == PH_MODE))
      n = PH_DUMMY;
    if (c.has_mode && (ph == PH_OPC || ph == PH_ADDR))
      n = PH_MODE;
    if (c.ad_w != `W0 && ph == PH_OPC)
      n = PH_ADDR;
    return n;
  endfunction

  // hi selects lane 1 for single-line traffic (memory to host)
  function automatic addr_t shift_in(addr_t sh, logic [3:0] io, width_t w, logic hi);
    case (w)
      `W1: return {sh[22:0], hi ? io[1] : io[0]};
      `W2: return {sh[21:0], io[1:0]};
      `W4: return {sh[19:0], io};
      default: return sh;
    endcase
  endfunction

  function automatic addr_t shift_out(addr_t sh, width_t w);
    case (w)
      `W1: return sh << 1;
      `W2: return sh << 2;
      `W4: return sh << 4;
      default: return sh;
    endcase
  endfunction

  function automatic logic [3:0] lanes(logic [7:0] b, width_t w, logic hi);
    case (w)
      `W1: return hi ? {2'h0, b[7], 1'h0} : {3'h0, b[7]};
      `W2: return {2'h0, b[7:6]};
      `W4: return b[7:4];
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] oe_n_for(width_t w, logic hi);
    case (w)
      `W1: return hi ? `OE_N_LANE1 : `OE_N_LANE0;
      `W2: return `OE_N_DUAL;
      `W4: return `OE_N_QUAD;
      default: return `OE_N_IDLE;
    endcase
  endfunction
endpackage

//--- src/spi_link_if.sv
`timescale 1ns/1ns
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_out;
  logic [3:0] host_oe_n;
  logic [3:0] dev_out;
  logic [3:0] dev_oe_n;
  logic [3:0] io;
  // a line nobody drives reads high, as with the usual pull-ups
  assign io = (~host_oe_n & host_out) | (~dev_oe_n & dev_out) | (host_oe_n & dev_oe_n);
  modport host(output cs_n, output sclk, output host_out, output host_oe_n, input io);
  modport dev(input cs_n, input sclk, input io, output dev_out, output dev_oe_n);
endinterface

//--- src/spi_flash_cmd_dev.sv
`timescale 1ns/1ns
`include "spi_flash_map.svh"
// What this block does
// - phase_width_code digits give address, mode and data widths
// - opcode always takes 8 clocks on one lane
// - mode bits [5:4] = 2: continuous read, next frame address first
// - address takes 24, 12 or 6 clocks
// - dual I/O read: 4 mode clocks after address
// - quad I/O reads: 2 mode clocks after address
// - data byte takes 8, 4 or 2 clocks
// - decode 4, 32, 64 kbyte block erases
// - status reads return exactly one byte
// - status writes accept exactly one byte
// - parameter table read: address, 8 dummy clocks
// - unique id read: 32 dummy clocks, no address
// - host frames commands by chip select, msb first
// - unknown opcode ignored until next frame
// - early chip select rise aborts, back to idle
module spi_flash_cmd_dev (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  spi_link_if.dev link,
  output spi_flash_pkg::opcode_t opcode_out,
  output spi_flash_pkg::addr_t addr_out,
  output logic [7:0] continuous_read_mode_bits_out,
  output logic continuous_read_out,
  output logic cmd_start_out,
  output logic [7:0] wr_byte_out,
  output logic wr_valid_out,
  output logic rd_req_out,
  input wire logic [7:0] rd_byte_in,
  output logic frame_end_out
);
  import spi_flash_pkg::*;

  logic sclk_q;
  logic cs_n_q;
  phase_e ph_q;
  phase_width_code_s cmd_q;
  logic [5:0] cnt_q;
  addr_t sh_q;
  addr_t tx_q;
  logic [7:0] nbyte_q;
  logic [3:0] out_q;
  logic [3:0] oe_n_q;

  logic rise;
  logic fall;
  logic start;
  logic hit;
  logic last;
  logic active;
  logic byte_lim;
  logic launch;
  logic load;
  width_t w;
  addr_t sin;
  phase_width_code_s dec;
  phase_width_code_s cur;
  phase_e np;
  logic [7:0] tx_byte;

  // pins are taken as synchronous; edges are found against last cycle's level
  assign rise = link.sclk & ~sclk_q;
  assign fall = ~link.sclk & sclk_q;
  assign start = ~link.cs_n & cs_n_q;
  assign hit = ce_in & ~link.cs_n & rise;
  assign active = ph_q == PH_OPC || ph_q == PH_ADDR || ph_q == PH_MODE ||
                  ph_q == PH_DUMMY || ph_q == PH_DATA;
  assign last = cnt_q == 6'h00;

  always_comb begin
    w = phase_width(ph_q, cmd_q);
    sin = shift_in(sh_q, link.io, w, 1'h0);
    dec = decode(sin[7:0]);
    cur = (ph_q == PH_OPC) ? dec : cmd_q;
    np = next_phase(ph_q, cur);
    byte_lim = cur.nb != `NB_OPEN && nbyte_q == {6'h00, cur.nb} - 8'h01;
    launch = hit && last && (ph_q == PH_OPC || ph_q == PH_ADDR || ph_q == PH_MODE) &&
             np != PH_ADDR && np != PH_MODE && (ph_q != PH_OPC || dec.known);
    load = cnt_q == len_m1(PH_DATA, cmd_q);
    tx_byte = load ? rd_byte_in : tx_q[23:16];
  end

  // the memory side must hand over rd_byte_in in the same cycle as this request
  assign rd_req_out = ce_in & fall & ~link.cs_n & (ph_q == PH_DATA) & cmd_q.da_out & load;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sclk_q <= 1'h0;
      cs_n_q <= 1'h1;
    end else if (ce_in) begin
      sclk_q <= link.sclk;
      cs_n_q <= link.cs_n;
    end
  end

  // phase sequencing, one serial clock per counter step
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ph_q <= PH_IDLE;
      cnt_q <= 6'h00;
      cmd_q <= '0;
    end else if (ce_in) begin
      if (link.cs_n) begin
        ph_q <= PH_IDLE;
      end else if (start) begin
        if (continuous_read_out) begin
          ph_q <= PH_ADDR;
          cnt_q <= len_m1(PH_ADDR, cmd_q);
        end else begin
          ph_q <= PH_OPC;
          cnt_q <= len_m1(PH_OPC, cmd_q);
        end
      end else if (hit && active) begin
        if (!last) begin
          cnt_q <= 6'(cnt_q - 6'h01);
        end else if (ph_q == PH_OPC && !dec.known) begin
          ph_q <= PH_DONE;
        end else if (ph_q == PH_DATA) begin
          if (byte_lim) begin
            ph_q <= PH_DONE;
          end else begin
            cnt_q <= len_m1(PH_DATA, cmd_q);
          end
        end else begin
          ph_q <= np;
          cnt_q <= len_m1(np, cur);
          if (ph_q == PH_OPC) begin
            cmd_q <= dec;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sh_q <= '0;
    end else if (hit) begin
      sh_q <= sin;
    end
  end

  // captured fields; in continuous mode the opcode from the earlier frame stays
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      opcode_out <= 8'h00;
      addr_out <= 24'h00_0000;
      continuous_read_mode_bits_out <= 8'h00;
      continuous_read_out <= 1'h0;
    end else if (hit && last) begin
      case (ph_q)
        PH_OPC: begin
          opcode_out <= sin[7:0];
        end
        PH_ADDR: begin
          addr_out <= sin;
        end
        PH_MODE: begin
          continuous_read_mode_bits_out <= sin[7:0];
          continuous_read_out <= sin[5:4] == `CONT_KEEP;
        end
        default: begin
          continuous_read_out <= continuous_read_out;
        end
      endcase
    end
  end

  // a command starts only once its opcode and any address and mode it has are all in
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cmd_start_out <= 1'h0;
      frame_end_out <= 1'h0;
    end else if (ce_in) begin
      cmd_start_out <= launch;
      frame_end_out <= link.cs_n & ~cs_n_q;
    end else begin
      cmd_start_out <= 1'h0;
      frame_end_out <= 1'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      nbyte_q <= 8'h00;
    end else if (ce_in) begin
      if (start) begin
        nbyte_q <= 8'h00;
      end else if (hit && last && ph_q == PH_DATA && nbyte_q != 8'hff) begin
        nbyte_q <= 8'(nbyte_q + 8'h01);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_valid_out <= 1'h0;
      wr_byte_out <= 8'h00;
    end else begin
      wr_valid_out <= hit && last && ph_q == PH_DATA && !cmd_q.da_out;
      if (hit && last && ph_q == PH_DATA && !cmd_q.da_out) begin
        wr_byte_out <= sin[7:0];
      end
    end
  end

  // output bits change on the falling serial edge so they are settled for the host's rise
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tx_q <= '0;
      out_q <= 4'h0;
      oe_n_q <= `OE_N_IDLE;
    end else if (ce_in) begin
      if (link.cs_n || ph_q != PH_DATA || !cmd_q.da_out) begin
        oe_n_q <= `OE_N_IDLE;
      end else if (fall) begin
        out_q <= lanes(tx_byte, w, 1'h1);
        oe_n_q <= oe_n_for(w, 1'h1);
        tx_q <= shift_out({tx_byte, 16'h0000}, w);
      end
    end
  end

  assign link.dev_out = out_q;
  assign link.dev_oe_n = oe_n_q;
endmodule

//--- src/spi_flash_cmd_host.sv
`timescale 1ns/1ns
`include "spi_flash_map.svh"
module spi_flash_cmd_host #(
  parameter int HALF_DIV = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  spi_link_if.host link,
  input wire logic start_in,
  input wire logic skip_opcode_in,
  input spi_flash_pkg::opcode_t opcode_in,
  input spi_flash_pkg::addr_t addr_in,
  input wire logic [7:0] mode_in,
  input wire logic [7:0] len_in,
  input wire logic [7:0] wr_byte_in,
  output logic wr_req_out,
  output logic [7:0] rd_byte_out,
  output logic rd_valid_out,
  output logic busy_out,
  output logic done_out
);
  import spi_flash_pkg::*;

  phase_e ph_q;
  phase_width_code_s c_q;
  logic [5:0] cnt_q;
  addr_t sh_q;
  addr_t rx_q;
  addr_t addr_q;
  logic [7:0] mode_q;
  logic [7:0] left_q;
  logic [15:0] div_q;
  logic half_q;
  logic cs_n_q;
  logic sclk_q;
  logic [3:0] out_q;
  logic [3:0] oe_n_q;

  logic tick;
  logic rise;
  logic end_ph;
  logic more;
  width_t w;
  addr_t rx_d;
  phase_e np;

  assign busy_out = ph_q != PH_IDLE;
  assign tick = ce_in && busy_out && div_q == 16'(HALF_DIV - 1);
  assign rise = tick && half_q;
  assign end_ph = rise && cnt_q == 6'h00;
  assign more = ph_q == PH_DATA && left_q != 8'h01;

  always_comb begin
    w = phase_width(ph_q, c_q);
    rx_d = shift_in(rx_q, link.io, w, 1'h1);
    np = next_phase(ph_q, c_q);
  end

  // write data must be valid in the cycle of this request
  assign wr_req_out = end_ph && !c_q.da_out &&
                      ((ph_q != PH_DATA && np == PH_DATA) || more);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !busy_out) begin
      div_q <= 16'h0000;
    end else if (ce_in) begin
      div_q <= tick ? 16'h0000 : 16'(div_q + 16'h0001);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ph_q <= PH_IDLE;
      c_q <= '0;
      cnt_q <= 6'h00;
      sh_q <= '0;
      rx_q <= '0;
      addr_q <= '0;
      mode_q <= 8'h00;
      left_q <= 8'h00;
      half_q <= 1'h0;
      cs_n_q <= 1'h1;
      sclk_q <= 1'h0;
      out_q <= 4'h0;
      oe_n_q <= `OE_N_IDLE;
      rd_valid_out <= 1'h0;
      rd_byte_out <= 8'h00;
      done_out <= 1'h0;
    end else if (ce_in) begin
      rd_valid_out <= 1'h0;
      done_out <= 1'h0;
      if (ph_q == PH_IDLE) begin
        if (start_in) begin
          c_q <= decode(opcode_in);
          ph_q <= skip_opcode_in ? PH_ADDR : PH_OPC;
          cnt_q <= len_m1(skip_opcode_in ? PH_ADDR : PH_OPC, decode(opcode_in));
          sh_q <= skip_opcode_in ? addr_in : {opcode_in, 16'h0000};
          addr_q <= addr_in;
          mode_q <= mode_in;
          left_q <= decode(opcode_in).nb != `NB_OPEN ? {6'h00, decode(opcode_in).nb} : len_in;
          half_q <= 1'h0;
          cs_n_q <= 1'h0;
        end
      end else if (tick && !half_q) begin
        sclk_q <= 1'h0;
        half_q <= 1'h1;
        if (ph_q == PH_DONE) begin
          // chip select rises with the clock low, ending the frame
          cs_n_q <= 1'h1;
          oe_n_q <= `OE_N_IDLE;
          ph_q <= PH_IDLE;
          done_out <= 1'h1;
        end else if (ph_q == PH_OPC || ph_q == PH_ADDR || ph_q == PH_MODE ||
                     (ph_q == PH_DATA && !c_q.da_out)) begin
          out_q <= lanes(sh_q[23:16], w, 1'h0);
          oe_n_q <= oe_n_for(w, 1'h0);
          sh_q <= shift_out(sh_q, w);
        end else begin
          oe_n_q <= `OE_N_IDLE;
        end
      end else if (rise) begin
        sclk_q <= 1'h1;
        half_q <= 1'h0;
        rx_q <= rx_d;
        if (cnt_q != 6'h00) begin
          cnt_q <= 6'(cnt_q - 6'h01);
        end else if (ph_q == PH_DATA) begin
          if (c_q.da_out) begin
            rd_valid_out <= 1'h1;
            rd_byte_out <= rx_d[7:0];
          end
          left_q <= 8'(left_q - 8'h01);
          cnt_q <= len_m1(PH_DATA, c_q);
          sh_q <= {wr_byte_in, 16'h0000};
          if (!more) begin
            ph_q <= PH_DONE;
          end
        end else begin
          ph_q <= np;
          cnt_q <= len_m1(np, c_q);
          case (np)
            PH_ADDR: sh_q <= addr_q;
            PH_MODE: sh_q <= {mode_q, 16'h0000};
            default: sh_q <= {wr_byte_in, 16'h0000};
          endcase
        end
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.host_out = out_q;
  assign link.host_oe_n = oe_n_q;
endmodule

//--- test/spi_link_monitor.sv
`timescale 1ns/1ns
module spi_link_monitor (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] io
);
  logic sclk_q;
  logic [7:0] rise_q;
  logic [7:0] op_q;
  logic rise;
  // rise_q counts serial clock rises already seen in this frame
  assign rise = sclk && !sclk_q;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) sclk_q <= 1'h0;
    else sclk_q <= sclk;
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || cs_n) rise_q <= 8'h00;
    else if (rise && rise_q != 8'hff) rise_q <= rise_q + 8'h01;
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) op_q <= 8'h00;
    else if (rise && !cs_n && rise_q < 8'h08) op_q <= {op_q[6:0], io[0]};
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // two settled cycles of deselect, so a registered chip select is allowed for
  idle_clock_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !sclk)
    else $error("serial clock moves while deselected");
  lane_contention_a: assert property ((~host_oe_n & ~dev_oe_n) == 4'h0)
    else $error("both ends drive one lane");
  dev_release_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> dev_oe_n == 4'hf)
    else $error("memory drives while deselected");
  opcode_lane_a: assert property (rise && rise_q < 8'h08 |-> host_oe_n == 4'he && dev_oe_n == 4'hf)
    else $error("opcode not on one host lane");
  status_byte_a: assert property (rise && op_q inside {8'h05, 8'h35, 8'h15} && rise_q >= 8'h08 &&
    rise_q < 8'h10 |-> dev_oe_n == 4'hd) else $error("status byte not on lane one");
  erase_quiet_a: assert property (rise && op_q inside {8'h20, 8'h52, 8'hd8} && rise_q >= 8'h08 |->
    host_oe_n == 4'he && dev_oe_n == 4'hf) else $error("erase frame misdriven");
  uid_dummy_a: assert property (rise && op_q == 8'h4b && rise_q >= 8'h08 |->
    dev_oe_n == (rise_q < 8'h28 ? 4'hf : 4'hd)) else $error("unique id dummy wrong");
  param_dummy_a: assert property (rise && op_q == 8'h5a && rise_q >= 8'h08 |->
    dev_oe_n == (rise_q < 8'h28 ? 4'hf : 4'hd)) else $error("parameter dummy wrong");
  dual_id_a: assert property (rise && op_q == 8'h92 && rise_q >= 8'h08 |->
    (rise_q < 8'h14 ? host_oe_n == 4'hc : rise_q < 8'h18 || dev_oe_n == 4'hc))
    else $error("dual id phases wrong");
  quad_read_a: assert property (rise && op_q == 8'heb && rise_q >= 8'h08 |->
    (rise_q < 8'h10 ? host_oe_n == 4'h0 : rise_q < 8'h14 || dev_oe_n == 4'h0))
    else $error("quad read phases wrong");
  status_cover: cover property (rise && op_q == 8'h05 && rise_q == 8'h08);
  uid_cover: cover property (rise && op_q == 8'h4b && rise_q == 8'h28);
  quad_cover: cover property (rise && op_q == 8'heb && rise_q == 8'h14);
endmodule

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
  import spi_flash_pkg::*;
  logic core_clk_in = 1'h0;
  logic rst_h_n = 1'h0;
  logic rst_d_n = 1'h0;
  logic start_in = 1'h0;
  opcode_t opcode_in = 8'h00;
  addr_t addr_in = 24'h00_0000;
  logic [7:0] len_in = 8'h01;
  logic [7:0] nrd = 8'h00;
  logic [7:0] nwr = 8'h00;
  logic wr_req, rd_valid, busy, done, rd_req, cmd_start, wr_valid, frame_end, cont;
  logic [7:0] rd_byte, wr_byte, mode_bits, last_rd, last_wr;
  opcode_t opcode;
  addr_t addr;
  int err_count = 0;
  int checks = 0;
  int n_start, n_rd, n_rv, n_wr, n_fe, n_dn;
  // opcode, len, read bytes, written bytes, flags: 1 addr, 2 mode, 4 unknown
  logic [31:0] tbl [0:27] = '{32'h0504_1000, 32'h3504_1000, 32'h1504_1000, 32'h0104_0100,
    32'h3104_0100, 32'h1104_0100, 32'h2004_0001, 32'h5204_0001, 32'hd804_0001, 32'hc704_0000,
    32'h6004_0000, 32'h7504_0000, 32'h7a04_0000, 32'hff04_0004, 32'h9f04_3000, 32'h9004_2001,
    32'h9204_2001, 32'h9404_2001, 32'h4404_0001, 32'h0203_0301, 32'h3202_0201, 32'h4201_0101,
    32'h5a02_2001, 32'h4b02_2000, 32'h4801_1001, 32'hbb02_2003, 32'heb02_2003, 32'he702_2003};
  always #5 core_clk_in = ~core_clk_in;
  // byte sources advance on the edge that takes a byte, so each byte is known in advance
  always @(posedge core_clk_in) begin
    if (rd_req === 1'h1) nrd <= nrd + 8'h01;
    if (wr_req === 1'h1) nwr <= nwr + 8'h01;
  end
  spi_link_if i_spi_link_if();
  spi_flash_cmd_host #(.HALF_DIV(2)) i_spi_flash_cmd_host (.core_clk_in(core_clk_in),
    .rst_n_in(rst_h_n), .ce_in(1'h1), .link(i_spi_link_if), .start_in(start_in),
    .skip_opcode_in(1'h0), .opcode_in(opcode_in), .addr_in(addr_in), .mode_in(8'h05),
    .len_in(len_in), .wr_byte_in(8'h3c + nwr), .wr_req_out(wr_req), .rd_byte_out(rd_byte),
    .rd_valid_out(rd_valid), .busy_out(busy), .done_out(done));
  spi_flash_cmd_dev i_spi_flash_cmd_dev (.core_clk_in(core_clk_in), .rst_n_in(rst_d_n),
    .ce_in(1'h1), .link(i_spi_link_if), .opcode_out(opcode), .addr_out(addr),
    .continuous_read_mode_bits_out(mode_bits), .continuous_read_out(cont),
    .cmd_start_out(cmd_start), .wr_byte_out(wr_byte), .wr_valid_out(wr_valid),
    .rd_req_out(rd_req), .rd_byte_in(8'ha5 + nrd), .frame_end_out(frame_end));
  spi_link_monitor i_spi_link_monitor (.core_clk_in(core_clk_in), .rst_n_in(rst_h_n & rst_d_n),
    .cs_n(i_spi_link_if.cs_n), .sclk(i_spi_link_if.sclk), .host_oe_n(i_spi_link_if.host_oe_n),
    .dev_oe_n(i_spi_link_if.dev_oe_n), .io(i_spi_link_if.io));
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr;
    n_start = 0;
    n_rd = 0;
    n_rv = 0;
    n_wr = 0;
    n_fe = 0;
    n_dn = 0;
  endtask
  task automatic tick;
    @(posedge core_clk_in);
    #1;
    if (cmd_start === 1'h1) n_start++;
    if (rd_req === 1'h1) n_rd++;
    if (wr_valid === 1'h1) n_wr++;
    if (frame_end === 1'h1) n_fe++;
    if (done === 1'h1) n_dn++;
    if (wr_valid === 1'h1) last_wr = wr_byte;
    if (rd_valid === 1'h1) n_rv++;
    if (rd_valid === 1'h1) last_rd = rd_byte;
  endtask
  task automatic run(input logic [31:0] r);
    int i;
    logic [7:0] b_rd, b_wr;
    b_rd = nrd;
    b_wr = nwr;
    clr();
    opcode_in = r[31:24];
    len_in = r[23:16];
    addr_in = {r[31:24], 16'h5a3c};
    start_in = 1'h1;
    tick();
    start_in = 1'h0;
    for (i = 0; i < 2000 && n_fe == 0; i++) tick();
    if (n_fe == 0) begin
      err_count++;
      $display("ERROR at %0t: frame did not end", $time);
      stop_test();
    end
    chk(24'(n_start), {23'h0, !r[2]});
    chk(24'(n_rd), 24'(r[15:12]));
    chk(24'(n_rv), 24'(r[15:12]));
    chk(24'(n_wr), 24'(r[11:8]));
    if (n_rd > 0) chk(24'(last_rd), 24'(8'(8'ha5 + b_rd + n_rd - 1)));
    chk(24'(n_dn), 24'h00_0001);
    chk({23'h0, busy}, 24'h00_0000);
    if (n_wr > 0) chk(24'(last_wr), 24'(8'(8'h3c + b_wr + n_wr - 1)));
    if (!r[2]) chk(24'(opcode), 24'(r[31:24]));
    if (r[0]) chk(addr, addr_in);
    if (r[1]) chk({15'h0, cont, mode_bits}, 24'h00_0005);
  endtask
  initial begin
    int i;
    repeat (12) @(posedge core_clk_in);
    #1;
    rst_h_n = 1'h1;
    rst_d_n = 1'h1;
    for (i = 0; i < 28; i++) run(tbl[i]);
    // host reset in mid-address is the only way to raise chip select early
    opcode_in = 8'hd8;
    start_in = 1'h1;
    tick();
    start_in = 1'h0;
    repeat (40) tick();
    clr();
    rst_h_n = 1'h0;
    tick();
    rst_h_n = 1'h1;
    repeat (30) tick();
    chk(24'(n_start), 24'h00_0000);
    chk(24'(n_fe), 24'h00_0001);
    run(32'h0504_1000);
    stop_test();
  end
endmodule
